// *** rtl/tbf_pkg.sv ***
// shared constants and types of the type b framing and block layer
package tbf_pkg;
   localparam int CLK_KHZ = 100000;
   // bit rates in kbit/s and the cycles of one elementary time unit at each
   localparam int RATE_LO_KBPS = 106;
   localparam int RATE_MID_KBPS = 212;
   localparam int RATE_HI_KBPS = 424;
   localparam logic [9:0] ETU_LO = 10'(CLK_KHZ / RATE_LO_KBPS);
   localparam logic [9:0] ETU_MID = 10'(CLK_KHZ / RATE_MID_KBPS);
   localparam logic [9:0] ETU_HI = 10'(CLK_KHZ / RATE_HI_KBPS);
   localparam int SC_KHZ = 848;
   localparam logic [5:0] SC_HALF = 6'(CLK_KHZ / (2 * SC_KHZ));
   // delimiter lengths in etu
   localparam logic [3:0] SOF_LOW_ETU = 4'hA;
   localparam logic [3:0] SOF_HIGH_ETU = 4'h2;
   localparam logic [3:0] EOF_LOW_ETU = 4'hA;
   localparam logic [3:0] SOF_LOW_MIN = 4'h9;
   localparam logic [3:0] SOF_LOW_MAX = 4'hB;
   localparam logic [3:0] SOF_HIGH_MAX = 4'h3;
   localparam logic [3:0] GAP_MAX_ETU = 4'hE;
   localparam logic [3:0] STOP_BIT = 4'h9;
   // field sizes in bytes
   localparam logic [8:0] MAX_FIELD = 9'h100;
   localparam logic [8:0] MIN_FIELD = 9'h003;
   localparam logic [8:0] CRC_BYTES = 9'h002;
   localparam logic [7:0] MAX_INF = 8'hFD;
   localparam logic [7:0] TX_MAX = 8'hFE;
   localparam logic [7:0] PCB_OPT_MASK = 8'hF3;
   // crc_b: reflected poly, preset ones, complemented output
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
   typedef enum logic [1:0] {TBF_R106, TBF_R212, TBF_R424} tbf_rate_e;
   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } tbf_byte_s;
endpackage

// *** rtl/tbf_frame.sv ***
// type b framer: air-side characters, sof/eof, crc_b and block checks
//
// Behaviour
// R1 - Characters go lsb first as a low start bit, eight data bits and a high stop bit, no parity.
// R2 - The link runs at 106, 212 or 424 kbit/s, held fixed for a whole exchange.
// R3 - Replies leave as bpsk on an 848 kHz subcarrier; commands arrive as nrz levels from ask.
// R4 - Every frame sent is wrapped in a start delimiter before and an end delimiter after the data.
// R5 - A frame's data field is at most 256 bytes long.
// R6 - The data field is a control byte, then the information field, then a two-byte crc_b.
// R7 - The information field holds 0 to 253 bytes.
// R8 - No card identifier or node address byte is ever added after the control byte.
// R9 - A received frame with a bad crc_b or an overlong data field is dropped without reply.
`timescale 1ns/10ps
`default_nettype none
module tbf_frame (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire tbf_pkg::tbf_rate_e rate_i,
   input  wire logic              rx_pin_i,
   output logic                   lm_o,
   output tbf_pkg::tbf_byte_s     rx_o,
   output logic                   rx_valid_o,
   input  wire logic              rx_ready_i,
   output logic                   rx_drop_o,
   input  wire tbf_pkg::tbf_byte_s tx_i,
   input  wire logic              tx_valid_i,
   output logic                   tx_ready_o,
   output logic                   tx_busy_o
);
   typedef enum logic [2:0] {RX_IDLE, RX_SOFL, RX_SOFH, RX_BITS, RX_GAP} tbf_rx_e;
   typedef enum logic [2:0] {TX_IDLE, TX_SOFL, TX_SOFH, TX_CHAR, TX_EOF} tbf_tx_e;

   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ tbf_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [9:0] etu_of(input tbf_pkg::tbf_rate_e r);
      case (r)
         tbf_pkg::TBF_R212: etu_of = tbf_pkg::ETU_MID;
         tbf_pkg::TBF_R424: etu_of = tbf_pkg::ETU_HI;
         default:           etu_of = tbf_pkg::ETU_LO;
      endcase
   endfunction

   // pin synchroniser: a level counts once the second and third stages agree
   logic s1, s2, s3, rx_lvl, rx_prev;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         rx_lvl <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         s1 <= rx_pin_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            rx_lvl <= s3;
         end
         rx_prev <= rx_lvl;
      end
   end
   wire rx_fall = rx_prev & ~rx_lvl;
   wire rx_rise = ~rx_prev & rx_lvl;

   tbf_rx_e     rx_state;
   tbf_tx_e     tx_state;
   logic [9:0]  rx_tmr;
   logic [3:0]  rx_ecnt;
   logic [3:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic [8:0]  rx_len;
   logic        rx_ovf;
   logic [15:0] rx_crc;
   tbf_pkg::tbf_rate_e rx_rate;
   logic [7:0]  mem [0:255];
   logic        dlv_busy;
   logic [7:0]  dlv_idx;
   logic [7:0]  dlv_end;

   wire [9:0] rx_etu = etu_of(rx_rate);
   wire rx_tick = (rx_tmr == 10'h000);
   wire rx_stop = (rx_state == RX_BITS) && rx_tick && (rx_bit == tbf_pkg::STOP_BIT);
   wire rx_wr = rx_stop && rx_lvl && (rx_len != tbf_pkg::MAX_FIELD);
   // eof reads as a character of all zeros whose stop bit is low too
   wire rx_eof = rx_stop && !rx_lvl && (rx_sh == 8'h00);
   wire rx_good = !rx_ovf && (rx_len >= tbf_pkg::MIN_FIELD)
                  && (rx_crc == tbf_pkg::CRC_RESIDUE);

   // receive: nrz levels, sampled mid-bit, delimiters measured in etu
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rx_state <= RX_IDLE;
         rx_tmr <= 10'h000;
         rx_ecnt <= 4'h0;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_len <= 9'h000;
         rx_ovf <= 1'b0;
         rx_crc <= tbf_pkg::CRC_INIT;
         rx_rate <= tbf_pkg::TBF_R106;
      end else begin
         // reload one short so that a bit lasts exactly one etu, not one etu plus a cycle
         rx_tmr <= rx_tick ? rx_etu - 10'h001 : rx_tmr - 10'h001;
         case (rx_state)
            RX_IDLE: begin
               // half duplex: no new frame while replying or still handing one out
               if (rx_fall && !dlv_busy && tx_state == TX_IDLE) begin
                  rx_state <= RX_SOFL;
                  rx_rate <= rate_i; // [R2]
                  rx_tmr <= etu_of(rate_i) - 10'h001;
                  rx_ecnt <= 4'h0;
               end
            end
            RX_SOFL: begin
               if (rx_tick && rx_ecnt != 4'hF) begin
                  rx_ecnt <= rx_ecnt + 4'h1;
               end
               if (rx_rise) begin
                  rx_state <= (rx_ecnt >= tbf_pkg::SOF_LOW_MIN) ? RX_SOFH : RX_IDLE; // [R4]
                  rx_ecnt <= 4'h0;
                  rx_tmr <= rx_etu - 10'h001;
               end else if (rx_ecnt > tbf_pkg::SOF_LOW_MAX) begin
                  rx_state <= RX_IDLE;
               end
            end
            RX_SOFH: begin
               if (rx_tick) begin
                  rx_ecnt <= rx_ecnt + 4'h1;
               end
               if (rx_fall) begin
                  rx_state <= RX_BITS;
                  rx_tmr <= rx_etu >> 1;
                  rx_bit <= 4'h0;
                  rx_len <= 9'h000;
                  rx_ovf <= 1'b0;
                  rx_crc <= tbf_pkg::CRC_INIT;
               end else if (rx_ecnt > tbf_pkg::SOF_HIGH_MAX) begin
                  rx_state <= RX_IDLE;
               end
            end
            RX_BITS: begin
               if (rx_tick) begin
                  rx_bit <= rx_bit + 4'h1;
                  if (rx_bit == 4'h0 && rx_lvl) begin
                     rx_state <= RX_IDLE; // glitch, not a start bit
                  end else if (rx_bit != tbf_pkg::STOP_BIT && rx_bit != 4'h0) begin
                     rx_sh <= {rx_lvl, rx_sh[7:1]}; // [R1]
                  end else if (rx_bit == tbf_pkg::STOP_BIT) begin
                     if (rx_lvl) begin
                        rx_state <= RX_GAP;
                        rx_ecnt <= 4'h0;
                        rx_crc <= crc_upd(rx_crc, rx_sh);
                        if (rx_len == tbf_pkg::MAX_FIELD) begin
                           rx_ovf <= 1'b1; // [R5]
                        end else begin
                           rx_len <= rx_len + 9'h001;
                        end
                     end else begin
                        rx_state <= RX_IDLE;
                     end
                  end
               end
            end
            RX_GAP: begin
               if (rx_tick) begin
                  rx_ecnt <= rx_ecnt + 4'h1;
               end
               if (rx_fall) begin
                  rx_state <= RX_BITS;
                  rx_tmr <= rx_etu >> 1;
                  rx_bit <= 4'h0;
               end else if (rx_ecnt > tbf_pkg::GAP_MAX_ETU) begin
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rx_wr) begin
         mem[rx_len[7:0]] <= rx_sh;
      end
   end

   // two-entry buffer between the frame store and the command side
   tbf_pkg::tbf_byte_s bf [0:1];
   logic       bf_wp, bf_rp;
   logic [1:0] bf_cnt;
   wire bf_push = dlv_busy && (bf_cnt != 2'h2);
   wire bf_pop = rx_valid_o && rx_ready_i;
   assign rx_valid_o = (bf_cnt != 2'h0);
   assign rx_o = bf[bf_rp];

   // a frame is released only after its crc is known good, hence the store
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         dlv_busy <= 1'b0;
         dlv_idx <= 8'h00;
         dlv_end <= 8'h00;
         rx_drop_o <= 1'b0;
      end else begin
         rx_drop_o <= rx_eof && !rx_good; // [R9]
         if (rx_eof && rx_good) begin
            dlv_busy <= 1'b1;
            dlv_idx <= 8'h00;
            dlv_end <= 8'(rx_len - tbf_pkg::CRC_BYTES - 9'h001); // [R6]
         end else if (bf_push) begin
            dlv_idx <= dlv_idx + 8'h01;
            if (dlv_idx == dlv_end) begin
               dlv_busy <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         bf_wp <= 1'b0;
         bf_rp <= 1'b0;
         bf_cnt <= 2'h0;
         bf[0] <= '0;
         bf[1] <= '0;
      end else begin
         if (bf_push) begin
            bf[bf_wp] <= '{last: dlv_idx == dlv_end, data: mem[dlv_idx]};
            bf_wp <= ~bf_wp;
         end
         if (bf_pop) begin
            bf_rp <= ~bf_rp;
         end
         bf_cnt <= bf_cnt + 2'(bf_push) - 2'(bf_pop);
      end
   end

   // transmit
   logic [9:0]  tx_tmr;
   logic [3:0]  tx_ecnt;
   logic [3:0]  tx_bit;
   logic [7:0]  tx_sh;
   logic [1:0]  tx_stage;
   logic        tx_last;
   logic        tx_first;
   logic [7:0]  tx_cnt;
   logic [15:0] tx_crc;
   tbf_pkg::tbf_rate_e tx_rate;
   logic        txbit;

   wire tx_tick = (tx_tmr == 10'h000);
   wire tx_eoc = (tx_state == TX_CHAR) && tx_tick && (tx_bit == tbf_pkg::STOP_BIT);
   wire [7:0] tx_cnt_n = tx_cnt + 8'h01;
   assign tx_ready_o = ((tx_state == TX_IDLE) && (rx_state == RX_IDLE) && !dlv_busy)
                       || (tx_eoc && tx_stage == 2'h0 && !tx_last);
   wire tx_take = tx_ready_o && tx_valid_i;
   assign tx_busy_o = (tx_state != TX_IDLE);

   always_comb begin
      txbit = 1'b1;
      case (tx_state)
         TX_SOFL, TX_EOF: txbit = 1'b0;
         TX_CHAR: begin
            if (tx_bit == 4'h0) begin
               txbit = 1'b0; // [R1]
            end else if (tx_bit != tbf_pkg::STOP_BIT) begin
               txbit = tx_sh[3'(tx_bit - 4'h1)]; // [R1]
            end
         end
         default: txbit = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         tx_state <= TX_IDLE;
         tx_tmr <= 10'h000;
         tx_ecnt <= 4'h0;
         tx_bit <= 4'h0;
         tx_sh <= 8'h00;
         tx_stage <= 2'h0;
         tx_last <= 1'b0;
         tx_first <= 1'b0;
         tx_cnt <= 8'h00;
         tx_crc <= tbf_pkg::CRC_INIT;
         tx_rate <= tbf_pkg::TBF_R106;
      end else begin
         if (tx_take) begin
            // first byte is the control byte: its cid and nad flags are cleared
            tx_sh <= (tx_state == TX_IDLE) ? (tx_i.data & tbf_pkg::PCB_OPT_MASK) : tx_i.data; // [R8]
            tx_crc <= crc_upd((tx_state == TX_IDLE) ? tbf_pkg::CRC_INIT : tx_crc,
                              (tx_state == TX_IDLE) ? (tx_i.data & tbf_pkg::PCB_OPT_MASK)
                                                    : tx_i.data);
            tx_cnt <= (tx_state == TX_IDLE) ? 8'h01 : tx_cnt_n;
            // control byte plus 253 information bytes ends the field regardless
            tx_last <= tx_i.last || ((tx_state != TX_IDLE) && tx_cnt_n == tbf_pkg::TX_MAX); // [R7]
            tx_first <= (tx_state == TX_IDLE);
         end
         if (tx_state != TX_IDLE && !(tx_eoc && tx_stage == 2'h0 && !tx_last && !tx_valid_i)) begin
            tx_tmr <= tx_tick ? etu_of(tx_rate) - 10'h001 : tx_tmr - 10'h001;
         end
         case (tx_state)
            TX_IDLE: begin
               if (tx_take) begin
                  tx_state <= TX_SOFL; // [R4]
                  tx_rate <= rate_i; // [R2]
                  tx_tmr <= etu_of(rate_i) - 10'h001;
                  tx_ecnt <= 4'h0;
                  tx_stage <= 2'h0;
               end
            end
            TX_SOFL: begin
               if (tx_tick) begin
                  tx_ecnt <= tx_ecnt + 4'h1;
                  if (tx_ecnt == tbf_pkg::SOF_LOW_ETU - 4'h1) begin
                     tx_state <= TX_SOFH;
                     tx_ecnt <= 4'h0;
                  end
               end
            end
            TX_SOFH: begin
               if (tx_tick) begin
                  tx_ecnt <= tx_ecnt + 4'h1;
                  if (tx_ecnt == tbf_pkg::SOF_HIGH_ETU - 4'h1) begin
                     tx_state <= TX_CHAR;
                     tx_bit <= 4'h0;
                  end
               end
            end
            TX_CHAR: begin
               if (tx_tick && tx_bit != tbf_pkg::STOP_BIT) begin
                  tx_bit <= tx_bit + 4'h1;
               end else if (tx_eoc) begin
                  // a late next byte only stretches the stop level
                  if (tx_stage == 2'h0 && !tx_last) begin
                     if (tx_valid_i) begin
                        tx_bit <= 4'h0;
                        tx_first <= 1'b0;
                     end
                  end else if (tx_stage == 2'h0) begin
                     tx_sh <= ~tx_crc[7:0]; // [R6]
                     tx_stage <= 2'h1;
                     tx_bit <= 4'h0;
                     tx_first <= 1'b0;
                  end else if (tx_stage == 2'h1) begin
                     tx_sh <= ~tx_crc[15:8]; // [R6]
                     tx_stage <= 2'h2;
                     tx_bit <= 4'h0;
                  end else begin
                     tx_state <= TX_EOF; // [R4]
                     tx_ecnt <= 4'h0;
                  end
               end
            end
            TX_EOF: begin
               if (tx_tick) begin
                  tx_ecnt <= tx_ecnt + 4'h1;
                  if (tx_ecnt == tbf_pkg::EOF_LOW_ETU - 4'h1) begin
                     tx_state <= TX_IDLE;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // subcarrier and bpsk: a low bit flips the subcarrier phase
   logic [5:0] sc_cnt;
   logic       sc;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sc_cnt <= 6'h00;
         sc <= 1'b0;
         lm_o <= 1'b0;
      end else begin
         sc_cnt <= (sc_cnt == 6'h00) ? tbf_pkg::SC_HALF - 6'h01 : sc_cnt - 6'h01;
         if (sc_cnt == 6'h00) begin
            sc <= ~sc;
         end
         lm_o <= (tx_state != TX_IDLE) && (sc ^ ~txbit); // [R3]
      end
   end

   a_tx_start_stop: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R1]
      (tx_state == TX_CHAR) |-> (tx_bit != 4'h0 || !txbit) && (tx_bit != 4'h9 || txbit))
      else $error("character framing bit wrong");
   a_rate_held: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R2]
      (tx_state != TX_IDLE) && $past(tx_state != TX_IDLE) |-> $stable(tx_rate))
      else $error("bit rate changed inside a frame");
   a_lm_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R3]
      (tx_state == TX_IDLE) [*2] |=> !lm_o)
      else $error("load modulation while idle");
   a_sof_length: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R4]
      (tx_state == TX_SOFL) ##1 (tx_state == TX_SOFH) |-> $past(tx_ecnt) == 4'h9)
      else $error("start delimiter length wrong");
   a_eof_after_crc: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R6]
      $rose(tx_state == TX_EOF) |-> $past(tx_stage) == 2'h2)
      else $error("end delimiter before crc");
   a_field_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R5]
      rx_eof && rx_ovf |=> rx_drop_o && !dlv_busy)
      else $error("receive field beyond limit");
   a_inf_limit: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R7]
      tx_take && tx_state != TX_IDLE |=> tx_cnt <= 8'hFE && (tx_cnt != 8'hFE || tx_last))
      else $error("information field too long");
   a_no_cid_nad: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R8]
      (tx_state == TX_SOFL || tx_first) |-> tx_sh[3:2] == 2'b00)
      else $error("cid or nad flag set in control byte");
   a_drop_bad: assert property (@(posedge ref_clk_i) disable iff (rst_i) // [R9]
      rx_eof && !rx_good && !rx_valid_o |=> rx_drop_o && !dlv_busy ##1 !rx_valid_o)
      else $error("bad frame not dropped");
endmodule
`default_nettype wire

// *** sim/tbf_reader.sv ***
// reader model: drives the command envelope and decodes the tag's bpsk reply
`timescale 1ns/10ps
`default_nettype none
module tbf_reader (
   input  wire logic ref_clk_i,
   input  wire logic lm_i,
   input  wire logic busy_i,
   output logic      pin_o
);
   logic [7:0] got [$];
   int         bad_bits;
   initial pin_o = 1'b1;
   task automatic hold(input logic lvl, input int n);
      pin_o = lvl;
      repeat (n) @(negedge ref_clk_i);
   endtask
   // frame: sof, lsb-first characters with start and stop, eof
   task automatic send_frame(input logic [7:0] b [$], input int etu);
      hold(1'b0, 10 * etu);
      hold(1'b1, 2 * etu);
      foreach (b[k]) begin
         hold(1'b0, etu);
         for (int j = 0; j < 8; j++) hold(b[k][j], etu);
         hold(1'b1, etu);
      end
      hold(1'b0, 10 * etu);
      hold(1'b1, etu);
   endtask
   // subcarrier period is measured over the sof so a slightly odd divider does not drift
   task automatic listen(input int etu);
      int         n, te, rises, ones;
      real        half;
      logic       prev, sc, done;
      logic [9:0] ch;
      got.delete();
      bad_bits = 0;
      n = 0;
      te = 0;
      rises = 0;
      half = 58.0;
      prev = 1'b1;
      @(posedge busy_i);
      repeat (12 * etu) begin
         @(negedge ref_clk_i);
         n++;
         if (lm_i && !prev) begin
            if (rises == 0) te = n;
            if (rises == 16) half = real'(n - te) / 32.0;
            rises++;
         end
         prev = lm_i;
      end
      done = 1'b0;
      while (!done) begin
         for (int k = 0; k < 10; k++) begin
            ones = 0;
            repeat (etu) begin
               @(negedge ref_clk_i);
               n++;
               sc = ($rtoi(real'(n - te) / half) % 2) == 1;
               if (lm_i === sc) ones++;
            end
            ch[k] = ones > etu / 2;
         end
         if (!ch[9]) done = 1'b1;
         else got.push_back(ch[8:1]);
         if (ch[0] || (!ch[9] && ch[8:1] != 8'h00)) bad_bits++;
      end
   endtask
endmodule
`default_nettype wire

// *** sim/typeb_frame_block_layer_tb.sv ***
// self-checking bench of the type b framer
`timescale 1ns/10ps
`default_nettype none
module typeb_frame_block_layer_tb;
   logic               ref_clk_i, rst_i, rx_pin_i, lm_o, rx_valid_o, rx_ready_i;
   logic               rx_drop_o, tx_valid_i, tx_ready_o, tx_busy_o;
   tbf_pkg::tbf_rate_e rate_i;
   tbf_pkg::tbf_byte_s rx_o, tx_i;
   tbf_pkg::tbf_byte_s rcv [$];
   int                 err_count, num_checks, drops, cycles;
   tbf_frame tbf_frame_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rate_i(rate_i),
      .rx_pin_i(rx_pin_i), .lm_o(lm_o), .rx_o(rx_o), .rx_valid_o(rx_valid_o),
      .rx_ready_i(rx_ready_i), .rx_drop_o(rx_drop_o), .tx_i(tx_i), .tx_valid_i(tx_valid_i),
      .tx_ready_o(tx_ready_o), .tx_busy_o(tx_busy_o));
   tbf_reader tbf_reader_i (.ref_clk_i(ref_clk_i), .lm_i(lm_o), .busy_i(tx_busy_o),
      .pin_o(rx_pin_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   task automatic stop_test();
      if (err_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         err_count++;
      end
   endtask
   function automatic logic [15:0] crc_b(input logic [7:0] b [$]);
      logic [15:0] c;
      c = tbf_pkg::CRC_INIT;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ tbf_pkg::CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction
   function automatic int etu_of(input tbf_pkg::tbf_rate_e r);
      return r == tbf_pkg::TBF_R106 ? int'(tbf_pkg::ETU_LO) :
             r == tbf_pkg::TBF_R212 ? int'(tbf_pkg::ETU_MID) : int'(tbf_pkg::ETU_HI);
   endfunction
   // consumer stalls at random so the buffer has to hold words back
   // the word standing now with ready raised is the one the next rising edge pops
   always @(negedge ref_clk_i) begin
      if (rx_drop_o === 1'b1) drops++;
      rx_ready_i = !rst_i && ($urandom % 4) != 0;
      if (rx_valid_o === 1'b1 && rx_ready_i) rcv.push_back(rx_o);
   end
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 115000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic rx_case(input tbf_pkg::tbf_rate_e r, input int ninf, input logic bad);
      logic [7:0]  f [$];
      logic [15:0] c;
      int          d0;
      rcv.delete();
      d0 = drops;
      rate_i = r;
      for (int k = 0; k <= ninf; k++) f.push_back(8'($urandom));
      c = crc_b(f) ^ {15'h0000, bad};
      tbf_reader_i.send_frame({f, c[7:0], c[15:8]}, etu_of(r));
      repeat (300) @(negedge ref_clk_i);
      check("rx count", 16'(rcv.size()), bad ? 16'h0000 : 16'(ninf + 1));
      check("rx drop", 16'(drops - d0), {15'h0000, bad});
      if (!bad) foreach (f[k]) check("rx byte", 16'(rcv[k]), {7'h00, k == ninf, f[k]});
   endtask
   task automatic tx_case(input int ninf);
      logic [7:0]  f [$];
      logic [7:0]  e [$];
      logic [15:0] c;
      rate_i = tbf_pkg::TBF_R424;
      f.push_back(8'($urandom) | 8'h0C);
      for (int k = 0; k < ninf; k++) f.push_back(8'($urandom));
      e = f;
      e[0] = f[0] & tbf_pkg::PCB_OPT_MASK;
      c = crc_b(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      fork
         tbf_reader_i.listen(etu_of(tbf_pkg::TBF_R424));
         begin
            foreach (f[k]) begin
               tx_i = {k == f.size() - 1, f[k]};
               tx_valid_i = 1'b1;
               #1;
               while (tx_ready_o !== 1'b1) begin
                  @(negedge ref_clk_i);
                  #1;
               end
               @(negedge ref_clk_i);
            end
            tx_valid_i = 1'b0;
         end
      join
      repeat (20) @(negedge ref_clk_i);
      check("tx count", 16'(tbf_reader_i.got.size()), 16'(e.size()));
      check("tx framing", 16'(tbf_reader_i.bad_bits), 16'h0000);
      foreach (e[k]) check("tx byte", {8'h00, tbf_reader_i.got[k]}, {8'h00, e[k]});
      check("tx idle", {14'h0000, tx_busy_o, lm_o}, 16'h0000);
   endtask
   initial begin
      rst_i = 1'b1;
      rate_i = tbf_pkg::TBF_R424;
      tx_i = 9'h000;
      tx_valid_i = 1'b0;
      rx_ready_i = 1'b0;
      err_count = 0;
      num_checks = 0;
      drops = 0;
      cycles = 0;
      void'($urandom(96));
      repeat (8) @(negedge ref_clk_i);
      check("reset outs", {11'h000, lm_o, rx_valid_o, rx_drop_o, tx_busy_o, tx_ready_o},
            16'h0001);
      rst_i = 1'b0;
      repeat (8) @(negedge ref_clk_i);
      rx_case(tbf_pkg::TBF_R424, 1 + ($urandom % 2), 1'b0);
      rx_case(tbf_pkg::TBF_R106, 0, 1'b0);
      rx_case(tbf_pkg::TBF_R212, 0, 1'b1);
      tx_case(1);
      stop_test();
   end
endmodule
`default_nettype wire
